// ---- src/port_aux_regs.svh ----
// Register offsets, field positions, reset values and fixed figures of the port aux block
`ifndef PORT_AUX_REGS_SVH
`define PORT_AUX_REGS_SVH

// ----------------------------------------------------------------------------
// Byte offsets of the register words
// ----------------------------------------------------------------------------
`define OFS_ANALOG_SELECT     5'h00
`define OFS_PULLUP_ENABLE     5'h04
`define OFS_CHANGE_IRQ_ENABLE 5'h08
`define OFS_PORT_A_DATA       5'h0c
`define OFS_PORT_DIRECTION    5'h10
`define OFS_POWER_CONTROL     5'h14
`define OFS_IRQ_CONTROL       5'h18
`define OFS_OPTION            5'h1c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_LOW_POWER_WAKE_ENABLE 5
`define BIT_GLOBAL_IRQ_ENABLE     7
`define BIT_CHANGE_IRQ_ON         3
`define BIT_PORT_CHANGE_FLAG      0
`define BIT_GLOBAL_PULLUP_DISABLE 7

// ----------------------------------------------------------------------------
// Implemented bits and reset values
// ----------------------------------------------------------------------------
`define PULLUP_IMPL_MASK      8'h37
`define PORT_IMPL_MASK        8'h3f
`define OSC_FORCED_MASK       8'h30
`define PIN_THREE_MASK        6'h08
`define RST_ANALOG_SELECT     8'hff
`define RST_PULLUP_ENABLE     8'h37
`define RST_CHANGE_IRQ_ENABLE 8'h00
`define RST_PORT_DIRECTION    6'h3f
`define RST_PORT_OUT          6'h00
`define RST_LOW_POWER_WAKE    1'h0
`define RST_GLOBAL_PULLUP_DIS 1'h1
`define RST_IRQ_CONTROL_BITS  1'h0

// ----------------------------------------------------------------------------
// Interrupt vector address
// ----------------------------------------------------------------------------
`define IRQ_VECTOR_ADDR 13'h0004

`endif

// ---- src/port_aux_pkg.sv ----
// Types of the port aux block
package port_aux_pkg;

  // Software controls
  typedef struct packed {
    logic [7:0] analog_select;
    logic [7:0] pullup_enable;
    logic [7:0] change_irq_enable;
    logic [5:0] port_out;
    logic [5:0] port_direction;
    logic       low_power_wake_enable;
    logic       global_irq_enable;
    logic       change_irq_on;
    logic       global_pullup_disable;
  } ctrl_t;

  // Pin drive bundle
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
    logic [5:0] pullup_on;
    logic [5:0] input_en;
    logic       sink_on;
  } pin_drive_t;

  // Whole state of the block
  typedef struct packed {
    ctrl_t      ctrl;
    logic       port_change_flag;
    logic [5:0] last_read;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] sync3;
    logic [5:0] pin_stable;
    logic       ack;
    logic [7:0] readdata;
    pin_drive_t drive;
    logic       irq;
    logic       wake;
  } state_t;

endpackage

// ---- src/port_pin_aux_functions.sv ----
// Port auxiliary pin logic: analog select, weak pull-ups, change detect, low-power wake
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`include "port_aux_regs.svh"

module port_pin_aux_functions (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        warm_reset,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        master_clear_enable,
  input  wire logic        crystal_osc_mode,
  input  wire logic [5:0]  pin_in,
  output logic      [5:0]  pin_out,
  output logic      [5:0]  pin_oe,
  output logic      [5:0]  pin_pullup_on,
  output logic      [5:0]  pin_input_en,
  output logic             pin_zero_sink_on,
  output logic             irq_req,
  output logic      [12:0] irq_vector,
  output logic             wake_req
);

  port_aux_pkg::state_t state_q;
  port_aux_pkg::state_t state_d;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Channels 0..3 sit on pins 0, 1, 2 and 4; pins 3 and 5 have none
  function automatic logic [5:0] pin_analog(input logic [7:0] sel);
    pin_analog = {1'b0, sel[3], 1'b0, sel[2], sel[1], sel[0]};
  endfunction

  // Bits forced high while a crystal oscillator owns pins 5 and 4
  function automatic logic [7:0] osc_forced(input logic [7:0] val, input logic xtal);
    osc_forced = xtal ? (val | `OSC_FORCED_MASK) : val;
  endfunction

  // Word offset of a bus address; byte lanes ignored
  function automatic logic [4:0] word_offset(input logic [4:0] addr);
    word_offset = {addr[4:2], 2'b00};
  endfunction

  // Level confirmed by two agreeing sampler stages, else the held level
  function automatic logic [5:0] agree_filter(input logic [5:0] mid,
                                              input logic [5:0] last,
                                              input logic [5:0] held);
    logic [5:0] same;
    same         = ~(mid ^ last);
    agree_filter = (same & last) | (~same & held);
  endfunction

  // Pull-up gating: enable bit, input mode, digital pin, global permit
  function automatic logic [5:0] pullup_gate(input logic [5:0] en,
                                             input logic [5:0] dir,
                                             input logic [5:0] analog,
                                             input logic       global_dis);
    pullup_gate = en & dir & ~analog & {6{~global_dis}} & ~`PIN_THREE_MASK;
  endfunction

  // --------------------------------------------------------------------------
  // Combinational view of the state
  // --------------------------------------------------------------------------
  logic [5:0] analog_pins;
  logic [7:0] pullup_view;
  logic [7:0] change_view;
  logic [5:0] port_read;
  logic [5:0] change_active;
  logic       mismatch;
  logic       req;
  logic       do_write;
  logic       do_read;
  logic       port_access;
  logic [7:0] wbyte;
  logic [7:0] rd_mux;

  always_comb begin
    analog_pins   = pin_analog(state_q.ctrl.analog_select);
    pullup_view   = osc_forced(state_q.ctrl.pullup_enable, crystal_osc_mode) & `PULLUP_IMPL_MASK;
    change_view   = osc_forced(state_q.ctrl.change_irq_enable, crystal_osc_mode) & `PORT_IMPL_MASK;
    // Analog pins read 0, pin 3 reads 0 as master clear
    port_read     = state_q.pin_stable & ~analog_pins;
    if (master_clear_enable) begin
      port_read = port_read & ~`PIN_THREE_MASK;
    end
    change_active = change_view[5:0] & ~analog_pins;
    mismatch      = |(change_active & (state_q.pin_stable ^ state_q.last_read));
    req           = avs_read | avs_write;
    do_write      = avs_write & state_q.ack & avs_byteenable[0];
    do_read       = avs_read & state_q.ack;
    port_access   = (do_write | do_read) && (word_offset(avs_address) == `OFS_PORT_A_DATA);
    wbyte         = avs_writedata[7:0];
  end

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    unique case (word_offset(avs_address))
      `OFS_ANALOG_SELECT: begin
        rd_mux = state_q.ctrl.analog_select;
      end
      `OFS_PULLUP_ENABLE: begin
        rd_mux = pullup_view;
      end
      `OFS_CHANGE_IRQ_ENABLE: begin
        rd_mux = change_view;
      end
      `OFS_PORT_A_DATA: begin
        rd_mux = {2'b00, port_read};
      end
      `OFS_PORT_DIRECTION: begin
        rd_mux = {2'b00, state_q.ctrl.port_direction | `PIN_THREE_MASK};
      end
      `OFS_POWER_CONTROL: begin
        rd_mux[`BIT_LOW_POWER_WAKE_ENABLE] = state_q.ctrl.low_power_wake_enable;
      end
      `OFS_IRQ_CONTROL: begin
        rd_mux[`BIT_GLOBAL_IRQ_ENABLE] = state_q.ctrl.global_irq_enable;
        rd_mux[`BIT_CHANGE_IRQ_ON]     = state_q.ctrl.change_irq_on;
        rd_mux[`BIT_PORT_CHANGE_FLAG]  = state_q.port_change_flag;
      end
      `OFS_OPTION: begin
        rd_mux[`BIT_GLOBAL_PULLUP_DISABLE] = state_q.ctrl.global_pullup_disable;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;

    // ------------------------------------------------------------------------
    // Three-stage pin sampling; a change counts once stages two and three agree
    // ------------------------------------------------------------------------
    state_d.sync1      = pin_in;
    state_d.sync2      = state_q.sync1;
    state_d.sync3      = state_q.sync2;
    state_d.pin_stable = agree_filter(state_q.sync2, state_q.sync3, state_q.pin_stable);

    // ------------------------------------------------------------------------
    // Bus slave: one wait state, answer registered
    // ------------------------------------------------------------------------
    state_d.ack = req & ~state_q.ack;
    if (req & ~state_q.ack) begin
      state_d.readdata = avs_read ? rd_mux : 8'h00;
    end

    // ------------------------------------------------------------------------
    // Register writes, lane 0 only
    // ------------------------------------------------------------------------
    if (do_write) begin
      unique case (word_offset(avs_address))
      `OFS_ANALOG_SELECT: begin
        state_d.ctrl.analog_select = wbyte;
      end
      `OFS_PULLUP_ENABLE: begin
        state_d.ctrl.pullup_enable = wbyte & `PULLUP_IMPL_MASK;
      end
      `OFS_CHANGE_IRQ_ENABLE: begin
        state_d.ctrl.change_irq_enable = wbyte & `PORT_IMPL_MASK;
      end
      `OFS_PORT_A_DATA: begin
        state_d.ctrl.port_out = wbyte[5:0];
      end
      `OFS_PORT_DIRECTION: begin
        state_d.ctrl.port_direction = wbyte[5:0] | `PIN_THREE_MASK;
      end
      `OFS_POWER_CONTROL: begin
        state_d.ctrl.low_power_wake_enable = wbyte[`BIT_LOW_POWER_WAKE_ENABLE];
      end
      `OFS_IRQ_CONTROL: begin
        state_d.ctrl.global_irq_enable = wbyte[`BIT_GLOBAL_IRQ_ENABLE];
        state_d.ctrl.change_irq_on     = wbyte[`BIT_CHANGE_IRQ_ON];
        state_d.port_change_flag       = wbyte[`BIT_PORT_CHANGE_FLAG];
      end
      `OFS_OPTION: begin
        state_d.ctrl.global_pullup_disable = wbyte[`BIT_GLOBAL_PULLUP_DISABLE];
      end
      default: ;
      endcase
    end

    // ------------------------------------------------------------------------
    // Any port read, or port write on lane 0, reloads the last-read latch
    // ------------------------------------------------------------------------
    if (port_access) begin
      state_d.last_read = port_read;
    end

    // ------------------------------------------------------------------------
    // Mismatch set wins over a software clear in the same cycle
    // ------------------------------------------------------------------------
    if (mismatch) begin
      state_d.port_change_flag = 1'b1;
    end

    // ------------------------------------------------------------------------
    // Pin drive: output path ignores analog select
    // ------------------------------------------------------------------------
    state_d.drive.out       = state_q.ctrl.port_out;
    state_d.drive.oe        = ~state_q.ctrl.port_direction & ~`PIN_THREE_MASK;
    state_d.drive.input_en  = ~analog_pins;
    state_d.drive.pullup_on = pullup_gate(pullup_view[5:0], state_q.ctrl.port_direction, analog_pins,
                                          state_q.ctrl.global_pullup_disable);
    if (master_clear_enable) begin
      state_d.drive.pullup_on = state_d.drive.pullup_on | `PIN_THREE_MASK;
    end
    state_d.drive.sink_on   = state_q.ctrl.low_power_wake_enable;

    // ------------------------------------------------------------------------
    // Wake ignores the global enable, the interrupt needs it
    // ------------------------------------------------------------------------
    state_d.wake = state_q.port_change_flag & state_q.ctrl.change_irq_on;
    state_d.irq  = state_q.port_change_flag & state_q.ctrl.change_irq_on &
                   state_q.ctrl.global_irq_enable;

    // ------------------------------------------------------------------------
    // Warm reset keeps the last-read latch and pin samplers
    // ------------------------------------------------------------------------
    if (!rst_n || warm_reset) begin
      state_d.ctrl.analog_select         = `RST_ANALOG_SELECT;
      state_d.ctrl.pullup_enable         = `RST_PULLUP_ENABLE;
      state_d.ctrl.change_irq_enable     = `RST_CHANGE_IRQ_ENABLE;
      state_d.ctrl.port_out              = `RST_PORT_OUT;
      state_d.ctrl.port_direction        = `RST_PORT_DIRECTION;
      state_d.ctrl.low_power_wake_enable = `RST_LOW_POWER_WAKE;
      state_d.ctrl.global_irq_enable     = `RST_IRQ_CONTROL_BITS;
      state_d.ctrl.change_irq_on         = `RST_IRQ_CONTROL_BITS;
      state_d.ctrl.global_pullup_disable = `RST_GLOBAL_PULLUP_DIS;
      state_d.port_change_flag           = `RST_IRQ_CONTROL_BITS;
      state_d.ack                        = 1'b0;
      state_d.readdata                   = 8'h00;
      state_d.drive                      = '0;
      state_d.drive.input_en             = 6'h00;
      state_d.irq                        = 1'b0;
      state_d.wake                       = 1'b0;
      state_d.last_read                  = warm_reset && rst_n ? state_q.last_read : 6'h00;
    end
    if (!rst_n) begin
      state_d.sync1      = 6'h00;
      state_d.sync2      = 6'h00;
      state_d.sync3      = 6'h00;
      state_d.pin_stable = 6'h00;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    state_q <= state_d;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign avs_waitrequest  = req & ~state_q.ack;
  assign avs_readdata     = {24'h000000, state_q.readdata};
  assign pin_out          = state_q.drive.out;
  assign pin_oe           = state_q.drive.oe;
  assign pin_pullup_on    = state_q.drive.pullup_on;
  assign pin_input_en     = state_q.drive.input_en;
  assign pin_zero_sink_on = state_q.drive.sink_on;
  assign irq_req          = state_q.irq;
  assign wake_req         = state_q.wake;
  assign irq_vector       = `IRQ_VECTOR_ADDR;

endmodule

// ---- test/port_pins_model.sv ----
// Far-side pin model: drivers, pull-ups and a charge capacitor on pin 0
`timescale 1ns/100ps
module port_pins_model #(parameter int CAP_CYCLES = 30) (
  input  wire logic       core_clk,
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] pin_pullup_on,
  input  wire logic       pin_zero_sink_on,
  input  wire logic [5:0] ext_level,
  input  wire logic [5:0] ext_drive,
  output logic      [5:0] pin_in
);
  int   cap_q   = 0;
  logic float_q = 1'b0;
  // ----------------------------------------
  // Capacitor on pin 0
  // ----------------------------------------
  always @(posedge core_clk) begin
    float_q <= ~float_q;
    if (pin_oe[0] && pin_out[0]) begin
      cap_q <= CAP_CYCLES;
    end else if (pin_oe[0]) begin
      cap_q <= 0;
    end else if (pin_zero_sink_on && cap_q > 0) begin
      cap_q <= cap_q - 1;
    end
  end
  // ----------------------------------------
  // Pin levels; floating pins other than pin 0 toggle
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_drive[i]) pin_in[i] = ext_level[i];
      else if (i == 0) pin_in[i] = (cap_q > 0);
      else if (pin_pullup_on[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_q;
    end
  end
endmodule

// ---- test/port_pin_aux_functions_props.sv ----
// Assertions on the port aux block ports
`timescale 1ns/100ps
`include "port_aux_regs.svh"
module port_pin_aux_functions_props (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        warm_reset,
  input  wire logic        master_clear_enable,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  input  wire logic [5:0]  pin_oe,
  input  wire logic [5:0]  pin_pullup_on,
  input  wire logic [5:0]  pin_input_en,
  input  wire logic        irq_req,
  input  wire logic [12:0] irq_vector,
  input  wire logic        wake_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_out_no_pull; (pin_pullup_on & pin_oe) == 6'h00; endproperty
  property p_master_clear_pin_pull;
    (rst_n && !warm_reset)[*2] |-> pin_pullup_on[3] == $past(master_clear_enable);
  endproperty
  property p_analog_quiet; (~pin_input_en & pin_pullup_on) == 6'h00; endproperty
  property p_fixed_dig; (rst_n && !warm_reset)[*2] |-> pin_input_en[3] && pin_input_en[5]; endproperty
  property p_por_pull; $rose(rst_n) |-> ((pin_pullup_on & 6'h37) == 6'h00)[*3]; endproperty
  property p_irq_wake; irq_req |-> wake_req; endproperty
  property p_vector; irq_req |-> irq_vector == `IRQ_VECTOR_ADDR; endproperty
  property p_analog_rd;
    avs_read && !avs_waitrequest && avs_address[4:2] == 3'h3 |-> (avs_readdata[7:0] & {2'b11, ~pin_input_en}) == 8'h00;
  endproperty
  a_out_no_pull: assert property (p_out_no_pull) else $error("pull-up on output pin");
  a_master_clear_pin_pull: assert property (p_master_clear_pin_pull) else $error("pin 3 pull-up wrong");
  a_analog_quiet: assert property (p_analog_quiet) else $error("pull-up on analog pin");
  a_fixed_dig: assert property (p_fixed_dig) else $error("pin 3 or 5 input off");
  a_por_pull: assert property (p_por_pull) else $error("pull-up on after power-on");
  a_irq_wake: assert property (p_irq_wake) else $error("irq without wake");
  a_vector: assert property (p_vector) else $error("bad vector");
  a_analog_rd: assert property (p_analog_rd) else $error("analog pin read not 0");
  c_irq: cover property ($rose(irq_req));
  c_wake_only: cover property (wake_req && !irq_req);
  c_port_rd: cover property (avs_read && !avs_waitrequest && avs_address[4:2] == 3'h3);
endmodule
bind port_pin_aux_functions port_pin_aux_functions_props i_props (.core_clk(core_clk), .rst_n(rst_n),
  .warm_reset(warm_reset), .master_clear_enable(master_clear_enable), .avs_address(avs_address),
  .avs_read(avs_read), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_oe(pin_oe),
  .pin_pullup_on(pin_pullup_on), .pin_input_en(pin_input_en), .irq_req(irq_req), .irq_vector(irq_vector),
  .wake_req(wake_req));

// ---- test/port_pin_aux_functions_tb.sv ----
// Self-checking bench of the port aux block
`timescale 1ns/100ps
module port_pin_aux_functions_tb;
  logic        core_clk = 0, rst_n = 0, warm_reset = 0, avs_read = 0, avs_write = 0;
  logic        master_clear_enable = 1, crystal_osc_mode = 0, pin_zero_sink_on, irq_req, wake_req;
  logic        avs_waitrequest;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [5:0]  pin_in, pin_out, pin_oe, pin_pullup_on, pin_input_en;
  logic [5:0]  ext_level = 6'h3c, ext_drive = 6'h3e;
  logic [12:0] irq_vector;
  int          bad_count = 0, check_count = 0, cycles = 0;
  localparam logic [21:0] ROWS [9] = '{{1'b0, 5'h00, 8'h00, 8'hff}, {1'b0, 5'h04, 8'h00, 8'h37},
    {1'b0, 5'h08, 8'h00, 8'h00}, {1'b1, 5'h00, 8'h5a, 8'h5a}, {1'b1, 5'h04, 8'hff, 8'h37},
    {1'b1, 5'h08, 8'hff, 8'h3f}, {1'b1, 5'h04, 8'h00, 8'h00}, {1'b1, 5'h08, 8'h00, 8'h00},
    {1'b1, 5'h00, 8'h00, 8'h00}};
  always #10 core_clk = ~core_clk;
  port_pin_aux_functions i_dut (.core_clk(core_clk), .rst_n(rst_n), .warm_reset(warm_reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .master_clear_enable(master_clear_enable), .crystal_osc_mode(crystal_osc_mode), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_on(pin_pullup_on), .pin_input_en(pin_input_en),
    .pin_zero_sink_on(pin_zero_sink_on), .irq_req(irq_req), .irq_vector(irq_vector), .wake_req(wake_req));
  port_pins_model i_pins (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_on(pin_pullup_on),
    .pin_zero_sink_on(pin_zero_sink_on), .ext_level(ext_level), .ext_drive(ext_drive), .pin_in(pin_in));
  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, a, d, x);
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task wait_wake;
    int n;
    n = 0;
    while (wake_req !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    chk(wake_req, 1'b1);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    chk({pin_pullup_on, pin_oe}, 12'h000);
    rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i][21]) wr(ROWS[i][20:16], ROWS[i][15:8]);
      rd(ROWS[i][20:16], ROWS[i][7:0]);
    end
    $display("register rows done");
    @(posedge core_clk);
    crystal_osc_mode <= 1'b1;
    rd(5'h04, 8'h30);
    rd(5'h08, 8'h30);
    crystal_osc_mode <= 1'b0;
    $display("crystal mode done");
    wr(5'h04, 8'h37);
    wr(5'h1c, 8'h00);
    settle(2);
    chk(pin_pullup_on, 6'h3f);
    wr(5'h10, 8'h3e);
    wr(5'h00, 8'h03);
    wr(5'h0c, 8'h01);
    settle(2);
    chk({pin_pullup_on, pin_input_en}, {6'h3c, 6'h3c});
    chk({pin_oe, pin_out}, {6'h01, 6'h01});
    rd(5'h0c, 8'h34);
    master_clear_enable <= 1'b0;
    settle(3);
    chk(pin_pullup_on, 6'h34);
    $display("pull-up test done");
    wr(5'h00, 8'h00);
    wr(5'h10, 8'h3f);
    wr(5'h08, 8'h02);
    wr(5'h18, 8'h88);
    rd(5'h0c, 8'h3d);
    ext_level[1] <= 1'b1;
    wait_wake();
    chk(irq_req, 1'b1);
    wr(5'h18, 8'h88);
    settle(8);
    rd(5'h18, 8'h89);
    rd(5'h0c, 8'h3f);
    wr(5'h18, 8'h88);
    settle(8);
    rd(5'h18, 8'h88);
    @(posedge core_clk);
    ext_level[2] <= 1'b0;
    settle(10);
    chk({irq_req, wake_req}, 2'b00);
    wr(5'h18, 8'h08);
    ext_level[1] <= 1'b0;
    wait_wake();
    chk(irq_req, 1'b0);
    $display("change test done");
    rd(5'h0c, 8'h39);
    wr(5'h18, 8'h08);
    ext_level[1] <= 1'b1;
    warm_reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    warm_reset <= 1'b0;
    wr(5'h00, 8'h00);
    wr(5'h08, 8'h02);
    wr(5'h18, 8'h08);
    wait_wake();
    $display("warm reset test done");
    rd(5'h0c, 8'h3b);
    wr(5'h10, 8'h3e);
    wr(5'h0c, 8'h01);
    wr(5'h08, 8'h01);
    wr(5'h10, 8'h3f);
    wr(5'h14, 8'h20);
    wr(5'h18, 8'h88);
    settle(2);
    chk({pin_zero_sink_on, wake_req}, 2'b10);
    wait_wake();
    chk({irq_req, irq_vector}, {1'b1, 13'h0004});
    $display("low-power wake test done");
    test_done();
  end
endmodule
